// *** src/priority_vectored_irq_ctrl.sv ***
// What this block does
// - One pending flip-flop per source, set by that source's event; GPIO and parallel port share one.
// - Pending stays set until serviced or reset.
// - Pending requests only when its enable register bit is set.
// - Global enable bits 0..6 map bus reset, ticks, hub, DAC, GPIO, two-wire.
// - Endpoint enable bits 0..4 map A0, A1, A2, B0, B1; upper bits reserved.
// - Reset clears both enable registers.
// - Winning request is taken only at an instruction boundary.
// - Fixed priority, vector 1 highest, vector 12 lowest.
// - Acknowledge clears CPU enable, clears pending, then calls the vector.
// - Vector address is two times the vector number.
// - Acknowledge call pushes program counter with carry and zero flags.
// - Return from service routine pops state and sets CPU enable.
// - Enable and disable instructions change only the CPU enable bit.
// - Status bit 7 shows any enabled pending request, regardless of CPU enable.
// - Call takes 10 cycles, the following jump 5 cycles.
// - Single-ended zero of 12 us or longer is a bus reset.
// - Bus reset sets status flag and clears address and hub port registers.
// - Bus reset event is raised when single-ended zero ends.
// - Endpoint event on final handshake of a transaction.
// - IN transaction without ACK raises no endpoint event.
// - Two periodic ticks, 128 us and 1.024 ms, with own vectors.
// - Nesting allowed once CPU enable is set inside a service routine.
// - Status enable-sense mirrors CPU enable; writes to it are ignored.
// - Parallel port events own the GPIO vector and block GPIO events.
//
// Local design decision: the AHB-Lite register port.
`include "irq_ctrl_defs.svh"
module priority_vectored_irq_ctrl
   import irq_ctrl_pkg::*;
#(
   parameter int TICK_FAST_CYC = `TICK_FAST_CYC,
   parameter int TICK_SLOW_CYC = `TICK_SLOW_CYC
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Sources
   input wire src_events_t srcEvents,
   input wire ep_events_t epEvents,
   input wire logic hapiEnable,
   input wire logic upstreamSe0,
   // CPU core
   input wire logic instrDone,
   input wire logic irqAck,
   input wire logic irqOnInstruction,
   input wire logic irqOffInstruction,
   input wire logic returnFromIsr,
   output logic irqReq,
   output logic [3:0] irqVector,
   output logic [15:0] vectorAddr,
   output logic pushPcFlags,
   output logic popPcFlags,
   output logic callActive,
   output logic jumpActive,
   output logic cpuIrqEnable,
   // Bus reset side effects
   output logic busResetClear
);
   logic [7:0] globalEn_r;
   logic [7:0] epEn_r;
   logic [12:1] pend_r;
   logic [12:1] pendClr;
   logic [12:1] pendSet;
   logic [12:1] enMask;
   logic [12:1] active;
   logic busRstFlag_r;
   logic gie_r;
   seq_state_t seq_r;
   logic [3:0] seqCnt_r;
   logic [3:0] winner;
   logic take;
   logic wrPend_r;
   logic [11:0] wrAddr_r;
   logic [17:0] tickFast_r;
   logic [17:0] tickSlow_r;
   logic tickFastEv;
   logic tickSlowEv;
   logic [11:0] se0Cnt_r;
   logic se0Det_r;
   logic se0Prev_r;
   logic busRstEv;
   logic busRstDet;

   // Lowest set vector number wins
   function automatic logic [3:0] pick(input logic [12:1] req);
      logic [3:0] v;
      v = 4'h0;
      for (int i = 12; i >= 1; i--) begin
         if (req[i]) begin
            v = 4'(i);
         end
      end
      return v;
   endfunction

   function automatic logic [15:0] vecAddr(input logic [3:0] v);
      return `VEC_BASE + 16'(v) * `VEC_STEP;
   endfunction

   // Periodic ticks; wide counters since the slow tick exceeds 16 bits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tickFast_r <= '0;
         tickSlow_r <= '0;
      end else if (ce) begin
         tickFast_r <= tickFastEv ? '0 : tickFast_r + 18'h0_0001;
         tickSlow_r <= tickSlowEv ? '0 : tickSlow_r + 18'h0_0001;
      end
   end
   assign tickFastEv = (tickFast_r == 18'(TICK_FAST_CYC - 1));
   assign tickSlowEv = (tickSlow_r == 18'(TICK_SLOW_CYC - 1));

   // Single-ended zero timer; counter saturates so long resets stay detected
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         se0Cnt_r <= '0;
         se0Det_r <= 1'b0;
         se0Prev_r <= 1'b0;
      end else if (ce) begin
         se0Prev_r <= upstreamSe0;
         if (!upstreamSe0) begin
            se0Cnt_r <= '0;
            se0Det_r <= 1'b0;
         end else if (se0Cnt_r != 12'(`SE0_MIN_CYC - 1)) begin
            se0Cnt_r <= se0Cnt_r + 12'h001;
         end else begin
            se0Det_r <= 1'b1;
         end
      end
   end
   assign busRstDet = upstreamSe0 && !se0Det_r && (se0Cnt_r == 12'(`SE0_MIN_CYC - 1));
   assign busRstEv = se0Prev_r && !upstreamSe0 && se0Det_r;

   // Clear pulse for address and hub port registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busResetClear <= 1'b0;
      end else if (ce) begin
         busResetClear <= busRstDet;
      end
   end

   // Event vector, bit index equals vector number
   always_comb begin
      pendSet = '0;
      pendSet[1] = busRstEv;
      pendSet[2] = tickFastEv;
      pendSet[3] = tickSlowEv;
      pendSet[8:4] = epEvents.done & epEvents.acked;
      pendSet[9] = srcEvents.hub;
      pendSet[10] = srcEvents.dac;
      pendSet[11] = hapiEnable ? srcEvents.parallel_handshake_port : srcEvents.gpio;
      pendSet[12] = srcEvents.twoWire;
   end

   // Enable mapping onto vectors
   assign enMask = {globalEn_r[6:3], epEn_r[4:0], globalEn_r[2:0]};
   assign active = pend_r & enMask;
   assign winner = pick(active);
   assign take = irqAck && instrDone && irqReq && (seq_r == SEQ_IDLE);

   // Pending flags; a new event beats the service clear
   always_comb begin
      pendClr = '0;
      if (take) begin
         pendClr[winner] = 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= '0;
      end else if (ce) begin
         pend_r <= (pend_r & ~pendClr) | pendSet;
      end
   end

   // CPU enable bit: only instructions and acknowledge touch it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gie_r <= 1'b0;
      end else if (ce) begin
         if (take) begin
            gie_r <= 1'b0;
         end else if (irqOnInstruction || returnFromIsr) begin
            gie_r <= 1'b1;
         end else if (irqOffInstruction) begin
            gie_r <= 1'b0;
         end
      end
   end

   // Call and jump sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seq_r <= SEQ_IDLE;
         seqCnt_r <= '0;
      end else if (ce) begin
         case (seq_r)
            SEQ_IDLE: begin
               if (take) begin
                  seq_r <= SEQ_CALL;
                  seqCnt_r <= 4'(`CALL_CYCLES - 1);
               end
            end
            SEQ_CALL: begin
               if (seqCnt_r == 4'h0) begin
                  seq_r <= SEQ_JUMP;
                  seqCnt_r <= 4'(`JUMP_CYCLES - 1);
               end else begin
                  seqCnt_r <= seqCnt_r - 4'h1;
               end
            end
            SEQ_JUMP: begin
               if (seqCnt_r == 4'h0) begin
                  seq_r <= SEQ_IDLE;
               end else begin
                  seqCnt_r <= seqCnt_r - 4'h1;
               end
            end
            default: begin
               seq_r <= SEQ_IDLE;
            end
         endcase
      end
   end

   // Registered CPU-facing outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irqReq <= 1'b0;
         irqVector <= 4'h0;
         vectorAddr <= `VEC_BASE;
         pushPcFlags <= 1'b0;
         popPcFlags <= 1'b0;
         callActive <= 1'b0;
         jumpActive <= 1'b0;
         cpuIrqEnable <= 1'b0;
      end else if (ce) begin
         irqReq <= gie_r && !take && (active & ~pendClr) != '0 && seq_r == SEQ_IDLE;
         irqVector <= pick(active & ~pendClr);
         if (take) begin
            vectorAddr <= vecAddr(winner);
         end
         pushPcFlags <= take;
         popPcFlags <= returnFromIsr;
         callActive <= (seq_r == SEQ_IDLE && take) || (seq_r == SEQ_CALL && seqCnt_r != 4'h0);
         jumpActive <= (seq_r == SEQ_CALL && seqCnt_r == 4'h0) || (seq_r == SEQ_JUMP && seqCnt_r != 4'h0);
         cpuIrqEnable <= gie_r;
      end
   end

   // AHB address phase capture; writes land in the data phase
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
      end else if (ce) begin
         if (hready) begin
            wrPend_r <= hsel && htrans[1] && hwrite;
            wrAddr_r <= haddr[11:0];
         end
      end
   end

   // Enable registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         globalEn_r <= `ENABLE_RST;
         epEn_r <= `ENABLE_RST;
      end else if (ce && wrPend_r) begin
         if (wrAddr_r == `ADDR_GLOBAL_EN) begin
            globalEn_r <= hwdata[7:0] & `GLOBAL_EN_MASK;
         end
         if (wrAddr_r == `ADDR_EP_EN) begin
            epEn_r <= hwdata[7:0] & `EP_EN_MASK;
         end
      end
   end

   // Bus reset status flag; detection beats a software clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busRstFlag_r <= 1'b0;
      end else if (ce) begin
         if (busRstDet) begin
            busRstFlag_r <= 1'b1;
         end else if (wrPend_r && wrAddr_r == `ADDR_STATUS) begin
            busRstFlag_r <= hwdata[`ST_BUSRST_BIT];
         end
      end
   end

   // Read data registered at address phase: zero wait states
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= '0;
            case (haddr[11:0])
               `ADDR_GLOBAL_EN: hrdata[7:0] <= globalEn_r;
               `ADDR_EP_EN: hrdata[7:0] <= epEn_r;
               `ADDR_STATUS: begin
                  hrdata[`ST_PEND_BIT] <= (active != '0);
                  hrdata[`ST_BUSRST_BIT] <= busRstFlag_r;
                  hrdata[`ST_SENSE_BIT] <= gie_r;
               end
               default: hrdata <= '0;
            endcase
         end
      end
   end

   // Checks
   // Call phase run length; a counter instead of a long repetition
   logic [4:0] callRun_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         callRun_r <= '0;
      end else if (ce) begin
         callRun_r <= callActive ? callRun_r + 5'h01 : 5'h00;
      end
   end

   sequence s_take;
      take && ce;
   endsequence
   sequence s_call;
      callActive [*8] ##1 callActive [*2] ##1 jumpActive;
   endsequence

   property p_pend_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && pend_r[5] && !pendClr[5] |=> pend_r[5];
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending flag lost");

   property p_ack_clears;
      @(posedge clk_sys) disable iff (!rst_n)
      s_take and !pendSet[winner] |=> !pend_r[$past(winner)] && !gie_r;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear flag");

   property p_priority;
      @(posedge clk_sys) disable iff (!rst_n)
      active[1] |-> winner == 4'h1;
   endproperty
   a_priority: assert property (p_priority) else $error("bus reset not top priority");

   property p_take_boundary;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(pushPcFlags) |-> $past(instrDone) && $past(irqAck);
   endproperty
   a_take_boundary: assert property (p_take_boundary) else $error("taken mid instruction");

   property p_vec_addr;
      @(posedge clk_sys) disable iff (!rst_n)
      s_take |=> vectorAddr == {11'h000, $past(winner), 1'b0};
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");

   property p_call_len;
      @(posedge clk_sys) disable iff (!rst_n)
      $fell(callActive) |-> callRun_r == 5'(`CALL_CYCLES);
   endproperty
   a_call_len: assert property (p_call_len) else $error("call phase length wrong");

   property p_call_seq;
      @(posedge clk_sys) disable iff (!rst_n || !ce)
      $rose(pushPcFlags) |-> s_call;
   endproperty
   a_call_seq: assert property (p_call_seq) else $error("call length wrong");

   property p_sense;
      @(posedge clk_sys) disable iff (!rst_n)
      ##1 cpuIrqEnable == $past(gie_r);
   endproperty
   a_sense: assert property (p_sense) else $error("enable sense mismatch");

   property p_no_nak_event;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && !pend_r[4] && !(epEvents.done[0] && epEvents.acked[0]) |=> !pend_r[4];
   endproperty
   a_no_nak_event: assert property (p_no_nak_event) else $error("endpoint event without ack");

   property p_busrst_end;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && !pend_r[1] && upstreamSe0 |=> !pend_r[1];
   endproperty
   a_busrst_end: assert property (p_busrst_end) else $error("bus reset event before se0 end");

endmodule // priority_vectored_irq_ctrl

// *** inc/irq_ctrl_defs.svh ***
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH
// Register indices and byte addresses
`define IDX_GLOBAL_EN 8'h20
`define IDX_EP_EN 8'h21
`define IDX_STATUS 8'hFF
`define ADDR_GLOBAL_EN 12'h080
`define ADDR_EP_EN 12'h084
`define ADDR_STATUS 12'h3FC
// Field positions
`define ST_PEND_BIT 7
`define ST_BUSRST_BIT 5
`define ST_SENSE_BIT 2
`define GLOBAL_EN_MASK 8'h7F
`define EP_EN_MASK 8'h1F
`define ENABLE_RST 8'h00
// Vector table
`define VEC_BASE 16'h0000
`define VEC_STEP 16'h0002
// Timing
`define CLK_MHZ 200
`define CALL_CYCLES 10
`define JUMP_CYCLES 5
`define SE0_MIN_US 12
`define SE0_MIN_CYC (`SE0_MIN_US * `CLK_MHZ)
`define TICK_FAST_NS 128000
`define TICK_FAST_CYC (`TICK_FAST_NS * `CLK_MHZ / 1000)
`define TICK_SLOW_NS 1024000
`define TICK_SLOW_CYC (`TICK_SLOW_NS * `CLK_MHZ / 1000)
`endif

// *** inc/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;
   // Peripheral event pulses, one per source class
   typedef struct packed {
      logic hub;
      logic dac;
      logic gpio;
      logic parallel_handshake_port;
      logic twoWire;
   } src_events_t;
   // Endpoint transaction end and whether the final handshake was an ACK
   typedef struct packed {
      logic [4:0] done;
      logic [4:0] acked;
   } ep_events_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CALL = 2'b01,
      SEQ_JUMP = 2'b10
   } seq_state_t;
endpackage

// *** tb/cpu_core_model.sv ***
module cpu_core_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Request from controller
   input wire logic irqReq,
   input wire logic [3:0] instrLen,
   // Boundary and acknowledge
   output logic instrDone,
   output logic irqAck
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;
   // Acks only on a boundary, so a slow instruction delays the take
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
         instrDone <= 1'b0;
         irqAck <= 1'b0;
      end else begin
         cnt_r <= (cnt_r >= instrLen) ? 4'h0 : cnt_r + 4'h1;
         instrDone <= (cnt_r >= instrLen);
         irqAck <= (cnt_r >= instrLen) && irqReq;
      end
   end
endmodule // cpu_core_model

// *** tb/tb_priority_vectored_irq_ctrl.sv ***
`include "irq_ctrl_defs.svh"
module tb_priority_vectored_irq_ctrl import irq_ctrl_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   src_events_t srcEvents;
   ep_events_t epEvents;
   logic hapiEnable, upstreamSe0, instrDone, irqAck, irqReq;
   logic irqOnInstruction, irqOffInstruction, returnFromIsr;
   logic [3:0] irqVector, instrLen;
   logic [15:0] vectorAddr;
   logic pushPcFlags, popPcFlags, callActive, jumpActive, cpuIrqEnable, busResetClear;
   logic hresp, ce;
   int fail_count = 0;
   int compares = 0;
   int brc = 0;
   logic [3:0] expVec [10] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
   assign hready = hreadyout;
   // Short tick periods keep the run brief
   priority_vectored_irq_ctrl #(.TICK_FAST_CYC(20), .TICK_SLOW_CYC(50)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .srcEvents(srcEvents),
      .epEvents(epEvents), .hapiEnable(hapiEnable), .upstreamSe0(upstreamSe0),
      .instrDone(instrDone), .irqAck(irqAck), .irqOnInstruction(irqOnInstruction),
      .irqOffInstruction(irqOffInstruction), .returnFromIsr(returnFromIsr), .irqReq(irqReq),
      .irqVector(irqVector), .vectorAddr(vectorAddr), .pushPcFlags(pushPcFlags),
      .popPcFlags(popPcFlags), .callActive(callActive), .jumpActive(jumpActive),
      .cpuIrqEnable(cpuIrqEnable), .busResetClear(busResetClear));
   cpu_core_model cpu (.clk_sys(clk_sys), .rst_n(rst_n), .irqReq(irqReq),
      .instrLen(instrLen), .instrDone(instrDone), .irqAck(irqAck));
   // Clock
   initial clk_sys = 1'b0;
   always #2.5 clk_sys = ~clk_sys;
   // Count bus reset side effect pulses
   always @(posedge clk_sys) begin
      if (busResetClear === 1'b1) brc++;
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Single word transfer; waits on hready for both phases
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0_0000, a};
      hwrite <= wr;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
      chk("response", 32'(hresp), 32'h0000_0000);
   endtask
   // One full take, call, jump and return
   task automatic serve(input logic [3:0] v);
      int n;
      logic [3:0] got;
      do @(posedge clk_sys); while (!(irqAck === 1'b1 && instrDone === 1'b1 && irqReq === 1'b1));
      got = irqVector;
      @(negedge clk_sys);
      chk("vector", 32'(got), 32'(v));
      chk("vector address", 32'(vectorAddr), 32'({v, 1'b0}));
      chk("push", 32'(pushPcFlags), 32'h0000_0001);
      n = 0;
      while (callActive === 1'b1 && n < 40) begin
         n++;
         @(negedge clk_sys);
      end
      chk("call cycles", 32'(n), 32'h0000_000A);
      n = 0;
      while (jumpActive === 1'b1 && n < 40) begin
         n++;
         @(negedge clk_sys);
      end
      chk("jump cycles", 32'(n), 32'h0000_0005);
      chk("cpu enable cleared", 32'(cpuIrqEnable), 32'h0000_0000);
      @(posedge clk_sys);
      returnFromIsr <= 1'b1;
      @(posedge clk_sys);
      returnFromIsr <= 1'b0;
      @(negedge clk_sys);
      chk("pop", 32'(popPcFlags), 32'h0000_0001);
      @(negedge clk_sys);
      chk("cpu enable set", 32'(cpuIrqEnable), 32'h0000_0001);
   endtask
   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      repeat (30000) @(posedge clk_sys);
      fail_count++;
      end_of_test();
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      ce = 1'b1;
      {srcEvents, epEvents, hapiEnable, upstreamSe0} = '0;
      {irqOnInstruction, irqOffInstruction, returnFromIsr} = '0;
      instrLen = 4'h3;
      rst_n = 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset values, masks and unmapped space
      ahb(1'b0, `ADDR_GLOBAL_EN, 32'h0);
      chk("global reset", rd, 32'h0000_0000);
      ahb(1'b0, `ADDR_EP_EN, 32'h0);
      chk("endpoint reset", rd, 32'h0000_0000);
      ahb(1'b1, `ADDR_GLOBAL_EN, 32'h0000_00FF);
      ahb(1'b0, `ADDR_GLOBAL_EN, 32'h0);
      chk("global mask", rd, 32'h0000_007F);
      ahb(1'b1, `ADDR_EP_EN, 32'h0000_00FF);
      ahb(1'b0, `ADDR_EP_EN, 32'h0);
      chk("endpoint mask", rd, 32'h0000_001F);
      ahb(1'b0, 12'h100, 32'h0);
      chk("unmapped", rd, 32'h0000_0000);
      // Every source but the parallel port fires while all masked
      ahb(1'b1, `ADDR_GLOBAL_EN, 32'h0);
      ahb(1'b1, `ADDR_EP_EN, 32'h0);
      @(posedge clk_sys);
      srcEvents <= 5'b11101;
      epEvents <= {5'h1F, 5'h1F};
      @(posedge clk_sys);
      srcEvents <= '0;
      epEvents <= '0;
      upstreamSe0 <= 1'b1;
      repeat (2500) @(posedge clk_sys);
      upstreamSe0 <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("bus reset pulses", 32'(brc), 32'h0000_0001);
      ahb(1'b0, `ADDR_STATUS, 32'h0);
      chk("pending masked", 32'(rd[`ST_PEND_BIT]), 32'h0);
      chk("bus reset flag", 32'(rd[`ST_BUSRST_BIT]), 32'h0000_0001);
      // Unmask all but ticks; CPU enable still off
      ahb(1'b1, `ADDR_EP_EN, 32'h0000_001F);
      ahb(1'b1, `ADDR_GLOBAL_EN, 32'h0000_0079);
      ahb(1'b0, `ADDR_STATUS, 32'h0);
      chk("pending seen", 32'(rd[`ST_PEND_BIT]), 32'h0000_0001);
      chk("enable sense", 32'(rd[`ST_SENSE_BIT]), 32'h0);
      chk("no request", 32'(irqReq), 32'h0);
      @(posedge clk_sys);
      irqOnInstruction <= 1'b1;
      @(posedge clk_sys);
      irqOnInstruction <= 1'b0;
      foreach (expVec[i]) serve(expVec[i]);
      // Unacked endpoint transaction stays silent
      @(posedge clk_sys);
      epEvents <= {5'h01, 5'h00};
      @(posedge clk_sys);
      epEvents <= '0;
      repeat (20) @(posedge clk_sys);
      chk("unacked", 32'(irqReq), 32'h0);
      // Parallel port owns the shared vector, slow instructions
      instrLen <= 4'h9;
      hapiEnable <= 1'b1;
      srcEvents <= 5'b00100;
      @(posedge clk_sys);
      srcEvents <= '0;
      repeat (20) @(posedge clk_sys);
      chk("gpio blocked", 32'(irqReq), 32'h0);
      srcEvents <= 5'b00010;
      @(posedge clk_sys);
      srcEvents <= '0;
      serve(4'hB);
      // Disable touches only the CPU bit
      @(posedge clk_sys);
      irqOffInstruction <= 1'b1;
      @(posedge clk_sys);
      irqOffInstruction <= 1'b0;
      ahb(1'b1, `ADDR_GLOBAL_EN, 32'h0000_007F);
      repeat (60) @(posedge clk_sys);
      chk("off no request", 32'(irqReq), 32'h0);
      ahb(1'b0, `ADDR_GLOBAL_EN, 32'h0);
      chk("global kept", rd, 32'h0000_007F);
      ahb(1'b0, `ADDR_STATUS, 32'h0);
      chk("tick pending", 32'(rd[`ST_PEND_BIT]), 32'h0000_0001);
      @(posedge clk_sys);
      irqOnInstruction <= 1'b1;
      @(posedge clk_sys);
      irqOnInstruction <= 1'b0;
      serve(4'h2);
      // Second reset mid-run
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      ahb(1'b0, `ADDR_GLOBAL_EN, 32'h0);
      chk("global after reset", rd, 32'h0000_0000);
      // Clock enable low: a write must not land
      ce <= 1'b0;
      ahb(1'b1, `ADDR_GLOBAL_EN, 32'h0000_007F);
      ce <= 1'b1;
      ahb(1'b0, `ADDR_GLOBAL_EN, 32'h0);
      chk("frozen write", rd, 32'h0000_0000);
      end_of_test();
   end
endmodule // tb_priority_vectored_irq_ctrl
